// [common/assr_defs.svh]
`ifndef ASSR_DEFS_SVH
`define ASSR_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASSR_OFF_CMD     8'h00
`define ASSR_OFF_INT_EN  8'h04
`define ASSR_OFF_MAIN    8'h08
`define ASSR_OFF_ERR     8'h0c
`define ASSR_OFF_CAUSE   8'h10
`define ASSR_OFF_IN_XY   8'h14
`define ASSR_OFF_IN_ZU   8'h18
`define ASSR_OFF_RB_LO   8'h1c
`define ASSR_OFF_RB_HI   8'h20
// ----------------------------------------
// command codes and fields
// ----------------------------------------
`define ASSR_CMD_NOP     8'h0f
`define ASSR_CMD_RD_LP   8'h10
`define ASSR_CMD_RD_RP   8'h11
`define ASSR_CMD_RD_SPD  8'h12
`define ASSR_CMD_RD_ACC  8'h13
`define ASSR_CMD_DRV_LO  8'h20
`define ASSR_CMD_DRV_HI  8'h23
`define ASSR_CMD_CLR     8'h25
`define ASSR_CMD_AXIS_LSB 8
// ----------------------------------------
// responses
// ----------------------------------------
`define ASSR_RESP_OKAY   2'h0
`define ASSR_RESP_SLVERR 2'h2
`endif

// [common/assr_pkg.sv]
package assr_pkg;
   // synchronised pin levels, active low pins
   typedef struct packed {
      logic [3:0] plus_limit_input;
      logic [3:0] minus_limit_input;
      logic [3:0] servo_alarm_input;
      logic [3:0] stop0_input;
      logic [3:0] stop1_input;
      logic [3:0] zphase_stop_input;
      logic [3:0] jog_plus_input;
      logic [3:0] jog_minus_input;
      logic [3:0] in_position_input;
      logic       emergency_stop_input;
   } assr_pins_s;

   typedef logic [3:0][7:1] assr_cause_t;

   typedef struct packed {
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              awready;
      logic              wready;
      logic              aw_got;
      logic              w_got;
      logic [7:0]        waddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic [1:0]        axis_sel;
      assr_cause_t       int_en;
      assr_cause_t       cause;
      logic [3:0][7:0]   err;
      logic [3:0]        ge_minus;
      logic [3:0]        ge_plus;
      logic [31:0]       readback;
      logic              irq_n;
      logic [3:0]        stop_decel;
      logic [3:0]        stop_sudden;
   } assr_state_s;
endpackage : assr_pkg

// [rtl/assr_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module assr_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   // ----------------------------------------
   // two stage synchroniser, pins idle high
   // ----------------------------------------
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } assr_sync_s;

   assr_sync_s st_ff;
   assr_sync_s nxt_st;

   always_comb
   begin
      nxt_st.s1 = d_i;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         st_ff <= '1;
      else
         st_ff <= nxt_st;
   end

   assign q_o = st_ff.s2;
endmodule : assr_sync
`default_nettype wire

// [rtl/assr_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "assr_defs.svh"
module assr_top
   import assr_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic [7:0]        s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [7:0]        s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   input  wire assr_pins_s        pins_i,
   input  wire logic [3:0]        drv_active_i,
   input  wire logic [3:0]        drv_minus_i,
   input  wire logic [3:0]        drv_end_i,
   input  wire logic [3:0]        cspd_start_i,
   input  wire logic [3:0]        cspd_end_i,
   input  wire logic [3:0]        soft_lim_en_i,
   input  wire logic [3:0]        hard_sudden_i,
   input  wire logic [3:0]        cmp_real_i,
   input  wire logic [3:0]        home_step3_start_i,
   input  wire logic [3:0][4:0]   home_search_step_state_i,
   input  wire logic [3:0][31:0]  logic_pos_i,
   input  wire logic [3:0][31:0]  real_pos_i,
   input  wire logic [3:0][31:0]  comp_plus_i,
   input  wire logic [3:0][31:0]  comp_minus_i,
   input  wire logic [3:0][15:0]  cur_speed_i,
   input  wire logic [3:0][15:0]  cur_accel_i,
   output logic [3:0]             stop_decel_o,
   output logic [3:0]             stop_sudden_o,
   output logic                   interrupt_out_low_o
);
   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   logic [$bits(assr_pins_s)-1:0] pins_vec;
   assr_pins_s                    pins_s;

   assr_sync #(
      .W ($bits(assr_pins_s))
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .d_i       (pins_i),
      .q_o       (pins_vec)
   );

   assign pins_s = assr_pins_s'(pins_vec);

   assr_state_s st_ff;
   assr_state_s nxt_st;

   // ----------------------------------------
   // per axis status and events
   // ----------------------------------------
   logic [3:0]       ge_m_now;
   logic [3:0]       ge_p_now;
   assr_cause_t      ev;
   logic [3:0][7:0]  err_set;
   logic [3:0]       hard_dir;
   logic [3:0]       soft_dir;

   for (genvar a = 0; a < 4; a++)
   begin : g_axis
      logic [31:0] pos;
      logic        hp;
      logic        hm;
      logic        sp;
      logic        sm;
      logic        home_err;
      assign pos = cmp_real_i[a] ? real_pos_i[a] : logic_pos_i[a];
      assign ge_m_now[a] = $signed(pos) >= $signed(comp_minus_i[a]);
      assign ge_p_now[a] = $signed(pos) >= $signed(comp_plus_i[a]);
      // threshold crossings by edge of the compare result
      assign ev[a][1] = ge_m_now[a] & ~st_ff.ge_minus[a];
      assign ev[a][2] = ~ge_m_now[a] & st_ff.ge_minus[a];
      assign ev[a][3] = ~ge_p_now[a] & st_ff.ge_plus[a];
      assign ev[a][4] = ge_p_now[a] & ~st_ff.ge_plus[a];
      assign ev[a][5] = cspd_end_i[a];
      assign ev[a][6] = cspd_start_i[a];
      assign ev[a][7] = drv_end_i[a];
      assign hp = ~pins_s.plus_limit_input[a];
      assign hm = ~pins_s.minus_limit_input[a];
      // soft flags only in the matching drive direction
      assign sp = soft_lim_en_i[a] & drv_active_i[a] & ~drv_minus_i[a]
                  & $signed(pos) > $signed(comp_plus_i[a]);
      assign sm = soft_lim_en_i[a] & drv_active_i[a] & drv_minus_i[a]
                  & $signed(pos) < $signed(comp_minus_i[a]);
      assign home_err = home_step3_start_i[a]
                        & ~pins_s.zphase_stop_input[a];
      assign err_set[a] = {home_err, 1'b0,
                           ~pins_s.emergency_stop_input,
                           ~pins_s.servo_alarm_input[a],
                           hm, hp, sm, sp};
      assign hard_dir[a] = drv_active_i[a]
                           & (drv_minus_i[a] ? hm : hp);
      assign soft_dir[a] = sp | sm;
   end

   // ----------------------------------------
   // bus handshakes
   // ----------------------------------------
   logic        ar_hs;
   logic        aw_hs;
   logic        w_hs;
   logic        have_aw;
   logic        have_w;
   logic        do_wr;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [7:0]  cmd_code;
   logic [1:0]  cmd_axis;
   logic        cmd_wr;
   logic        rd_clr;

   assign ar_hs = s_axi_arvalid_i & st_ff.arready;
   assign aw_hs = s_axi_awvalid_i & st_ff.awready;
   assign w_hs = s_axi_wvalid_i & st_ff.wready;
   assign have_aw = st_ff.aw_got | aw_hs;
   assign have_w = st_ff.w_got | w_hs;
   assign do_wr = have_aw & have_w & ~st_ff.bvalid;
   assign wr_addr = st_ff.aw_got ? st_ff.waddr : s_axi_awaddr_i;
   assign wr_data = st_ff.w_got ? st_ff.wdata : s_axi_wdata_i;
   assign wr_strb = st_ff.w_got ? st_ff.wstrb : s_axi_wstrb_i;
   assign cmd_code = wr_data[7:0];
   assign cmd_axis = wr_data[`ASSR_CMD_AXIS_LSB +: 2];
   assign cmd_wr = do_wr & wr_strb[0] & (wr_addr == `ASSR_OFF_CMD);
   // any read of the cause word clears it, low byte included
   assign rd_clr = ar_hs & (s_axi_araddr_i == `ASSR_OFF_CAUSE);

   // ----------------------------------------
   // read data decode
   // ----------------------------------------
   logic [15:0] in_xy;
   logic [15:0] in_zu;
   logic [15:0] main_stat;
   logic [3:0]  err_sum;
   logic [3:0]  home_run;
   logic [31:0] rd_mux;
   logic        rd_ok;

   for (genvar a = 0; a < 4; a++)
   begin : g_sum
      assign err_sum[a] = |st_ff.err[a];
      assign home_run[a] = |home_search_step_state_i[a];
   end

   assign main_stat = {4'h0, home_run, err_sum, drv_active_i};

   // raw levels, high pin reads 1
   assign in_xy = {pins_s.servo_alarm_input[1],
                   pins_s.in_position_input[1],
                   pins_s.jog_minus_input[1],
                   pins_s.jog_plus_input[1], 1'b0,
                   pins_s.zphase_stop_input[1],
                   pins_s.stop1_input[1],
                   pins_s.stop0_input[1],
                   pins_s.servo_alarm_input[0],
                   pins_s.in_position_input[0],
                   pins_s.jog_minus_input[0],
                   pins_s.jog_plus_input[0],
                   pins_s.emergency_stop_input,
                   pins_s.zphase_stop_input[0],
                   pins_s.stop1_input[0],
                   pins_s.stop0_input[0]};
   assign in_zu = {pins_s.servo_alarm_input[3],
                   pins_s.in_position_input[3],
                   pins_s.jog_minus_input[3],
                   pins_s.jog_plus_input[3], 1'b0,
                   pins_s.zphase_stop_input[3],
                   pins_s.stop1_input[3],
                   pins_s.stop0_input[3],
                   pins_s.servo_alarm_input[2],
                   pins_s.in_position_input[2],
                   pins_s.jog_minus_input[2],
                   pins_s.jog_plus_input[2], 1'b0,
                   pins_s.zphase_stop_input[2],
                   pins_s.stop1_input[2],
                   pins_s.stop0_input[2]};

   always_comb
   begin
      rd_ok = 1'b1;
      rd_mux = 32'h0;
      unique case (s_axi_araddr_i)
         `ASSR_OFF_CMD:    rd_mux = {30'h0, st_ff.axis_sel};
         `ASSR_OFF_INT_EN: rd_mux = {24'h0,
                                     st_ff.int_en[st_ff.axis_sel], 1'b0};
         `ASSR_OFF_MAIN:   rd_mux = {16'h0, main_stat};
         `ASSR_OFF_ERR:    rd_mux = {19'h0,
            home_search_step_state_i[st_ff.axis_sel],
            st_ff.err[st_ff.axis_sel]};
         `ASSR_OFF_CAUSE:  rd_mux = {24'h0,
                                     st_ff.cause[st_ff.axis_sel],
                                     1'b0};
         `ASSR_OFF_IN_XY:  rd_mux = {16'h0, in_xy};
         `ASSR_OFF_IN_ZU:  rd_mux = {16'h0, in_zu};
         `ASSR_OFF_RB_LO:  rd_mux = {16'h0, st_ff.readback[15:0]};
         `ASSR_OFF_RB_HI:  rd_mux = {16'h0, st_ff.readback[31:16]};
         default:          rd_ok = 1'b0;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      // read channel
      if (ar_hs)
      begin
         nxt_st.arready = 1'b0;
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_mux;
         nxt_st.rresp = rd_ok ? `ASSR_RESP_OKAY : `ASSR_RESP_SLVERR;
      end
      else if (st_ff.rvalid && s_axi_rready_i)
      begin
         nxt_st.rvalid = 1'b0;
         nxt_st.arready = 1'b1;
      end
      // write channel, address and data in either order
      if (aw_hs)
      begin
         nxt_st.awready = 1'b0;
         nxt_st.aw_got = 1'b1;
         nxt_st.waddr = s_axi_awaddr_i;
      end
      if (w_hs)
      begin
         nxt_st.wready = 1'b0;
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata_i;
         nxt_st.wstrb = s_axi_wstrb_i;
      end
      if (do_wr)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.awready = 1'b0;
         nxt_st.wready = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = (wr_addr <= `ASSR_OFF_RB_HI && wr_addr[1:0] == 2'h0)
                        ? `ASSR_RESP_OKAY : `ASSR_RESP_SLVERR;
         if (wr_addr == `ASSR_OFF_INT_EN && wr_strb[0])
            nxt_st.int_en[st_ff.axis_sel] = wr_data[7:1];
      end
      else if (st_ff.bvalid && s_axi_bready_i)
      begin
         nxt_st.bvalid = 1'b0;
         nxt_st.awready = 1'b1;
         nxt_st.wready = 1'b1;
      end
      // commands
      if (cmd_wr)
      begin
         unique case (cmd_code)
            `ASSR_CMD_NOP:    nxt_st.axis_sel = cmd_axis;
            `ASSR_CMD_RD_LP:  nxt_st.readback = logic_pos_i[cmd_axis];
            `ASSR_CMD_RD_RP:  nxt_st.readback = real_pos_i[cmd_axis];
            `ASSR_CMD_RD_SPD: nxt_st.readback = {16'h0,
                                                 cur_speed_i[cmd_axis]};
            `ASSR_CMD_RD_ACC: nxt_st.readback = {16'h0,
                                                 cur_accel_i[cmd_axis]};
            default:          nxt_st.readback = st_ff.readback;
         endcase
      end
      // per axis flags, a new event beats a clear
      for (int a = 0; a < 4; a++)
      begin
         if (rd_clr && st_ff.axis_sel == 2'(a))
            nxt_st.cause[a] = '0;
         nxt_st.cause[a] = nxt_st.cause[a]
                           | (ev[a] & st_ff.int_en[a]);
         if (cmd_wr && cmd_axis == 2'(a)
             && ((cmd_code >= `ASSR_CMD_DRV_LO
                  && cmd_code <= `ASSR_CMD_DRV_HI)
                 || cmd_code == `ASSR_CMD_CLR))
            nxt_st.err[a] = '0;
         nxt_st.err[a] = nxt_st.err[a] | err_set[a];
         nxt_st.stop_sudden[a] = hard_dir[a] & hard_sudden_i[a];
         nxt_st.stop_decel[a] = drv_active_i[a]
            & (soft_dir[a] | (hard_dir[a] & ~hard_sudden_i[a]));
      end
      nxt_st.ge_minus = ge_m_now;
      nxt_st.ge_plus = ge_p_now;
      nxt_st.irq_n = ~(|nxt_st.cause);
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_ff <= '0;
         st_ff.arready <= 1'b1;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.irq_n <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign s_axi_arready_o = st_ff.arready;
   assign s_axi_rvalid_o = st_ff.rvalid;
   assign s_axi_rdata_o = st_ff.rdata;
   assign s_axi_rresp_o = st_ff.rresp;
   assign s_axi_awready_o = st_ff.awready;
   assign s_axi_wready_o = st_ff.wready;
   assign s_axi_bvalid_o = st_ff.bvalid;
   assign s_axi_bresp_o = st_ff.bresp;
   assign stop_decel_o = st_ff.stop_decel;
   assign stop_sudden_o = st_ff.stop_sudden;
   assign interrupt_out_low_o = st_ff.irq_n;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_hard_limit_err;
      !pins_s.plus_limit_input[0] |=> st_ff.err[0][2];
   endproperty
   a_hard_limit_err:
      assert property (p_hard_limit_err) else $error("limit bit not set");

   property p_home_err;
      home_step3_start_i[3] && !pins_s.zphase_stop_input[3]
         |=> st_ff.err[3][7] [*2];
   endproperty
   a_home_err:
      assert property (p_home_err) else $error("home error not set");

   property p_soft_dir;
      drv_active_i[0] && drv_minus_i[0] && !st_ff.err[0][0]
         && !(cmd_wr && cmd_axis == 2'h0)
         |=> !st_ff.err[0][0];
   endproperty
   a_soft_dir:
      assert property (p_soft_dir) else $error("soft plus set in reverse");

   property p_limit_stop;
      drv_active_i[0] && !drv_minus_i[0] && !pins_s.plus_limit_input[0]
         |=> stop_decel_o[0] || stop_sudden_o[0];
   endproperty
   a_limit_stop:
      assert property (p_limit_stop) else $error("no stop on limit");

   property p_drive_end;
      drv_end_i[1] && st_ff.int_en[1][7]
         |=> st_ff.cause[1][7] && !interrupt_out_low_o;
   endproperty
   a_drive_end:
      assert property (p_drive_end) else $error("drive end not flagged");

   property p_irq_level;
      (|st_ff.cause) == !interrupt_out_low_o;
   endproperty
   a_irq_level:
      assert property (p_irq_level) else $error("interrupt level wrong");

   property p_read_clear;
      rd_clr && st_ff.axis_sel == 2'h1
         && !(|(ev[1] & st_ff.int_en[1]))
         |=> st_ff.cause[1] == '0;
   endproperty
   a_read_clear:
      assert property (p_read_clear) else $error("cause not cleared");

   property p_cmp_minus;
      ev[1][1] && st_ff.int_en[1][1] |=> st_ff.cause[1][1];
   endproperty
   a_cmp_minus:
      assert property (p_cmp_minus) else $error("compare bit missing");

   property p_load_rb;
      cmd_wr && cmd_code == `ASSR_CMD_RD_LP && cmd_axis == 2'h2
         |=> st_ff.readback == $past(logic_pos_i[2]);
   endproperty
   a_load_rb:
      assert property (p_load_rb) else $error("readback not loaded");

   property p_rb_hi;
      ar_hs && s_axi_araddr_i == `ASSR_OFF_RB_HI && !cmd_wr
         |=> s_axi_rvalid_o
             && s_axi_rdata_o == {16'h0, st_ff.readback[31:16]};
   endproperty
   a_rb_hi:
      assert property (p_rb_hi) else $error("high word wrong");

   c_read_clear: cover property (rd_clr && (|st_ff.cause));
   c_write_done: cover property (st_ff.bvalid && s_axi_bready_i);
   c_home_err: cover property ($rose(st_ff.err[3][7]));
endmodule : assr_top
`default_nettype wire

// [verif/assr_host.sv]
`timescale 1ns/1ns
`default_nettype none
module assr_host (
   input  wire logic        clk_i,
   output logic [7:0]       aw_o,
   output logic             awv_o,
   input  wire logic        awr_i,
   output logic [31:0]      wd_o,
   output logic [3:0]       ws_o,
   output logic             wv_o,
   input  wire logic        wr_i,
   input  wire logic [1:0]  br_i,
   input  wire logic        bv_i,
   output logic             bq_o,
   output logic [7:0]       ar_o,
   output logic             arv_o,
   input  wire logic        arr_i,
   input  wire logic [31:0] rd_i,
   input  wire logic [1:0]  rr_i,
   input  wire logic        rv_i,
   output logic             rq_o
);
   // ----
   // axi-lite master
   // ----
   initial
   begin
      {aw_o, awv_o, wd_o, ws_o, wv_o, bq_o, ar_o, arv_o, rq_o} = '0;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_i);
      {aw_o, awv_o, wd_o, ws_o, wv_o, bq_o} <= {a, 1'b1, d, 4'hf, 2'h3};
      do
      begin
         @(posedge clk_i);
         if (awr_i) {awv_o, aw_o} <= {1'b0, ~a};
         if (wr_i) {wv_o, wd_o} <= {1'b0, ~d};
      end while (!bv_i);
      r = br_i;
      bq_o <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_i);
      {ar_o, arv_o, rq_o} <= {a, 2'h3};
      do
      begin
         @(posedge clk_i);
         if (arr_i) {arv_o, ar_o} <= {1'b0, ~a};
      end while (!rv_i);
      d = rd_i;
      r = rr_i;
      rq_o <= 1'b0;
   endtask : rd
endmodule : assr_host
`default_nettype wire

// [verif/tb_axis_status_interrupt_readback.sv]
`timescale 1ns/1ns
`default_nettype none
`include "assr_defs.svh"
module tb_axis_status_interrupt_readback
   import assr_pkg::*;
   ;
   logic sys_clk_i = 1'b0;
   logic rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
   logic s_axi_arvalid_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o, interrupt_out_low_o, s_axi_rready_i;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d, e;
   logic [3:0] s_axi_wstrb_i, drv_active_i, drv_minus_i, drv_end_i;
   logic [3:0] cspd_start_i, cspd_end_i, soft_lim_en_i, hard_sudden_i;
   logic [3:0] cmp_real_i, home_step3_start_i, stop_decel_o, stop_sudden_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
   assr_pins_s pins_i;
   logic [3:0][4:0] home_search_step_state_i;
   logic [3:0][31:0] logic_pos_i, real_pos_i, comp_plus_i, comp_minus_i;
   logic [3:0][15:0] cur_speed_i, cur_accel_i;
   logic [31:0] seed = 32'h00015baa;
   logic [63:0] r64;
   int n_errors = 0;
   int checks = 0;
   int pv;
   int q[$];

   assr_top u_assr_top (.*);
   assr_host u_assr_host (.clk_i(sys_clk_i), .aw_o(s_axi_awaddr_i),
      .awv_o(s_axi_awvalid_i), .awr_i(s_axi_awready_o),
      .wd_o(s_axi_wdata_i), .ws_o(s_axi_wstrb_i), .wv_o(s_axi_wvalid_i),
      .wr_i(s_axi_wready_o), .br_i(s_axi_bresp_o), .bv_i(s_axi_bvalid_o),
      .bq_o(s_axi_bready_i), .ar_o(s_axi_araddr_i),
      .arv_o(s_axi_arvalid_i), .arr_i(s_axi_arready_o),
      .rd_i(s_axi_rdata_o), .rr_i(s_axi_rresp_o), .rv_i(s_axi_rvalid_o),
      .rq_o(s_axi_rready_i));

   always #25 sys_clk_i = ~sys_clk_i;

   // ----
   // model and helpers
   // ----
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic logic [7:0] lv(input int a);
      return {pins_i.servo_alarm_input[a], pins_i.in_position_input[a],
              pins_i.jog_minus_input[a], pins_i.jog_plus_input[a], 1'b0,
              pins_i.zphase_stop_input[a], pins_i.stop1_input[a],
              pins_i.stop0_input[a]};
   endfunction : lv

   function automatic logic [31:0] cmpev(input int o, input int p);
      cmpev = '0;
      cmpev[4] = p >= 100 && o < 100;
      cmpev[3] = p < 100 && o >= 100;
      cmpev[2] = p < -100 && o >= -100;
      cmpev[1] = p >= -100 && o < -100;
   endfunction : cmpev

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         n_errors++;
         $display("unexpected %0t got %h want %h", $time, g, x);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : cyc

   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      u_assr_host.rd(a, d, r);
      chk(d, x);
   endtask : rchk

   task automatic w(input logic [7:0] a, input logic [31:0] v);
      u_assr_host.wr(a, v, r);
      chk(r, `ASSR_RESP_OKAY);
   endtask : w

   task automatic results();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   initial
   begin
      #200000;
      n_errors++;
      results();
   end

   initial
   begin
      rst_i = 1'b1;
      pins_i = '1;
      {drv_active_i, drv_minus_i, drv_end_i, cspd_start_i, cspd_end_i,
       soft_lim_en_i, hard_sudden_i, cmp_real_i, home_step3_start_i} = '0;
      {home_search_step_state_i, logic_pos_i, real_pos_i} = '0;
      {comp_plus_i, comp_minus_i, cur_speed_i, cur_accel_i} = '0;
      comp_plus_i[1] = 32'h00000064;
      comp_minus_i[1] = 32'hffffff9c;
      cyc(5);
      rst_i <= 1'b0;
      cyc(3);
      chk(interrupt_out_low_o, 32'h1);
      pins_i.plus_limit_input[0] <= 1'b0;
      drv_active_i[0] <= 1'b1;
      home_search_step_state_i[0] <= 5'h0a;
      cyc(5);
      chk(stop_decel_o, 32'h1);
      hard_sudden_i[0] <= 1'b1;
      cyc(2);
      chk({stop_sudden_o, stop_decel_o}, 32'h10);
      hard_sudden_i[0] <= 1'b0;
      rchk(`ASSR_OFF_ERR, 32'h0a04);
      rchk(`ASSR_OFF_MAIN, 32'h0111);
      pins_i.plus_limit_input[0] <= 1'b1;
      drv_active_i[0] <= 1'b0;
      cyc(5);
      rchk(`ASSR_OFF_ERR, 32'h0a04);
      w(`ASSR_OFF_CMD, 32'h25);
      rchk(`ASSR_OFF_ERR, 32'h0a00);
      {soft_lim_en_i[0], drv_active_i[0], drv_minus_i[0]} <= 3'h7;
      logic_pos_i[0] <= 32'h64;
      cyc(4);
      rchk(`ASSR_OFF_ERR, 32'h0a00);
      drv_minus_i[0] <= 1'b0;
      cyc(4);
      rchk(`ASSR_OFF_ERR, 32'h0a01);
      drv_active_i[0] <= 1'b0;
      // ----
      // cause register, axis 1
      // ----
      w(`ASSR_OFF_CMD, 32'h10f);
      w(`ASSR_OFF_INT_EN, 32'h80);
      drv_end_i[1] <= 1'b1;
      cyc(1);
      drv_end_i[1] <= 1'b0;
      cyc(2);
      chk(interrupt_out_low_o, 32'h0);
      rchk(`ASSR_OFF_CAUSE, 32'h80);
      chk(interrupt_out_low_o, 32'h1);
      rchk(`ASSR_OFF_CAUSE, 32'h0);
      w(`ASSR_OFF_INT_EN, 32'he0);
      {cspd_start_i[1], cspd_end_i[1]} <= 2'h3;
      cyc(1);
      {cspd_start_i[1], cspd_end_i[1]} <= 2'h0;
      cyc(2);
      rchk(`ASSR_OFF_CAUSE, 32'h60);
      w(`ASSR_OFF_INT_EN, 32'h1e);
      q = '{200, -200, 0};
      pv = 0;
      foreach (q[i])
      begin
         cmp_real_i[1] <= i[0];
         logic_pos_i[1] <= i[0] ? -q[i] : q[i];
         real_pos_i[1] <= i[0] ? q[i] : -q[i];
         cyc(4);
         rchk(`ASSR_OFF_CAUSE, cmpev(pv, q[i]));
         pv = q[i];
      end
      // ----
      // readback, home error, pin levels
      // ----
      logic_pos_i[2] <= xs() | 32'h80000000;
      real_pos_i[2] <= xs();
      cur_speed_i[2] <= 16'(xs());
      cur_accel_i[2] <= 16'(xs());
      cyc(1);
      for (int c = 0; c < 4; c++)
      begin
         w(`ASSR_OFF_CMD, 32'h210 + c);
         e = c == 0 ? logic_pos_i[2] : c == 1 ? real_pos_i[2] :
             c == 2 ? {16'h0, cur_speed_i[2]} : {16'h0, cur_accel_i[2]};
         rchk(`ASSR_OFF_RB_LO, {16'h0, e[15:0]});
         rchk(`ASSR_OFF_RB_HI, {16'h0, e[31:16]});
      end
      u_assr_host.rd(8'h40, d, r);
      chk(r, `ASSR_RESP_SLVERR);
      w(`ASSR_OFF_CMD, 32'h30f);
      pins_i.zphase_stop_input[3] <= 1'b0;
      cyc(3);
      home_step3_start_i[3] <= 1'b1;
      cyc(1);
      home_step3_start_i[3] <= 1'b0;
      cyc(2);
      rchk(`ASSR_OFF_ERR, 32'h80);
      repeat (3)
      begin
         r64 = {xs(), xs()};
         pins_i <= r64[36:0];
         cyc(4);
         e = {lv(1), lv(0)};
         e[3] = pins_i.emergency_stop_input;
         rchk(`ASSR_OFF_IN_XY, e);
         rchk(`ASSR_OFF_IN_ZU, {16'h0, lv(3), lv(2)});
      end
      results();
   end
endmodule : tb_axis_status_interrupt_readback
`default_nettype wire
